// >>> hdl/tsq_pkg.sv
// Constants and types for the trigger sequencer with min-max statistics
package tsq_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SETUP_MS = 20;
  localparam int SETUP_CYC = SETUP_MS * (CLK_HZ / 1000);
  localparam int US_CYC = CLK_HZ / 1_000_000;
  localparam logic [31:0] MAX_COUNT = 32'h0000_C350;
  localparam logic [31:0] MAX_DELAY_MS = 32'h0036_EE80;
  localparam logic [31:0] INF_COUNT = 32'h0000_0000;
  localparam logic [31:0] INF_READBACK = 32'h7E94_F56A;
  localparam logic [31:0] LIM120 = 32'h0001_D4C0;
  localparam logic [31:0] DB_LIM = 32'h0000_4E20;
  localparam int MEM_DEPTH = 512;
  localparam int MEM_AW = 9;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_DELAY = 8'h0C;
  localparam logic [7:0] A_SAMPLES = 8'h10;
  localparam logic [7:0] A_TRIGS = 8'h14;
  localparam logic [7:0] A_NULL = 8'h18;
  localparam logic [7:0] A_DBREL = 8'h1C;
  localparam logic [7:0] A_DBMRES = 8'h20;
  localparam logic [7:0] A_LOWER = 8'h24;
  localparam logic [7:0] A_UPPER = 8'h28;
  localparam logic [7:0] A_MIN = 8'h2C;
  localparam logic [7:0] A_MAX = 8'h30;
  localparam logic [7:0] A_AVG = 8'h34;
  localparam logic [7:0] A_CNT = 8'h38;
  localparam logic [7:0] A_POINTS = 8'h3C;
  localparam logic [7:0] A_FETCH = 8'h40;
  localparam logic [7:0] A_READING = 8'h44;
  localparam int CMD_ARM_STORE = 0;
  localparam int CMD_ARM_STREAM = 1;
  localparam int CMD_ONE_SHOT = 2;
  localparam int CMD_PRESET = 3;
  localparam int CMD_BUS_TRIG = 4;
  localparam int CMD_DEV_CLEAR = 5;
  localparam int CMD_IF_RESET = 6;
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_IMM = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [2:0] MATH_NONE = 3'h0;
  localparam logic [2:0] MATH_NULL = 3'h1;
  localparam logic [2:0] MATH_MINMAX = 3'h2;
  localparam logic [2:0] MATH_DB = 3'h3;
  localparam logic [2:0] MATH_DBM = 3'h4;
  localparam logic [2:0] MATH_LIMIT = 3'h5;
  localparam logic [31:0] AUTO_DELAY_US = 32'h0000_0064;
  localparam logic [15:0] DBM_DEFAULT = 16'h0258;
  typedef enum logic [1:0] {TSQ_IDLE, TSQ_SETUP, TSQ_WAIT, TSQ_MEAS} tsq_state_e;
endpackage : tsq_pkg

// >>> hdl/tsq_trigger_sequencer.sv
// Trigger sequencer, reading store and math registers behind an APB slave
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Min-max mode tracks smallest and largest reading, readable.
// - Min-max mode keeps reading count and running average, readable.
// - Statistics clear on min-max enable, reset, and interface reset.
// - Null offset written only with math on, within +-120% range.
// - dB reference written only with math on, within +-200.00 dBm.
// - Only listed power reference resistances 50..8000 ohms accepted, kept.
// - Lower and upper limits held, each within +-120% range.
// - Storage on keeps up to 512 readings; storage off discards them.
// - One-shot and preset commands re-enable reading storage.
// - Fetch with storage disabled raises an error.
// - Triggers outside wait-for-trigger ignored; accepted trigger starts sequence.
// - Local mode ready except during a measurement or the set-up after arming.
// - External triggers ignored for 20 ms after arming.
// - Arm-and-store goes idle to wait, readings kept in memory.
// - Arm-and-stream goes idle to wait, readings go to output.
// - Trigger source bus, immediate (default) or external, readable.
// - Programmable delay 0 to 3600 s before each sample.
// - Auto delay derived from settings; explicit delay write clears auto.
// - Readings per trigger programmable 1 to 50,000.
// - Return idle after trigger count; infinite until device clear.
// - Trigger count ignored under local control.
// - Infinite trigger count reads back as 9.9E+37 code.
// - Only one math operation enabled at any time.
module tsq_trigger_sequencer (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        extTrig,
  input  wire logic        localMode,
  input  wire logic        sampleDone,
  input  wire logic [31:0] sampleValue,
  input  wire logic [7:0]  autoDelayMs,
  output logic             sampleStart,
  output logic             streamValid,
  output logic [31:0]      streamData,
  output logic             waitTrig,
  output logic             errPulse
);
  typedef struct packed {
    logic        rs1;
    logic        rs2;
    logic        ext1;
    logic        ext2;
    logic        ext3;
    tsq_pkg::tsq_state_e st;
    logic        streamMode;
    logic        storeEn;
    logic        autoDelay;
    logic [1:0]  trigSrc;
    logic [2:0]  mathSel;
    logic        mathOn;
    logic        busTrig;
    logic [31:0] delayMs;
    logic [31:0] samples;
    logic [31:0] trigs;
    logic [31:0] nullVal;
    logic [31:0] dbRel;
    logic [15:0] dbmRes;
    logic [31:0] lower;
    logic [31:0] upper;
    logic [31:0] minV;
    logic [31:0] maxV;
    logic [47:0] sum;
    logic [31:0] cnt;
    logic [9:0]  points;
    logic [9:0]  rdPtr;
    logic [31:0] setupCnt;
    logic [31:0] usCnt;
    logic [31:0] msCnt;
    logic [31:0] delayLeft;
    logic        delaying;
    logic        busy;
    logic [31:0] sampLeft;
    logic [31:0] trigDone;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        sampleStart;
    logic        streamValid;
    logic [31:0] streamData;
    logic        waitTrig;
    logic        errPulse;
  } tsq_regs_s;

  tsq_regs_s r;
  tsq_regs_s next_r;
  logic [31:0] mem [tsq_pkg::MEM_DEPTH];
  logic        rstSync;
  logic        memWe;

  assign rstSync = r.rs2;

  function automatic logic inRange(input logic [31:0] v, input logic [31:0] lim);
    logic signed [31:0] s;
    s = v;
    return (s <= $signed(lim)) && (s >= -$signed(lim));
  endfunction : inRange

  function automatic logic dbmListed(input logic [31:0] v);
    case (v)
      32'd50, 32'd75, 32'd93, 32'd110, 32'd124, 32'd125, 32'd135, 32'd150,
      32'd250, 32'd300, 32'd500, 32'd600, 32'd800, 32'd900, 32'd1000,
      32'd1200, 32'd8000: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : dbmListed

  always_comb begin
    logic        wr;
    logic        rd;
    logic        extEdge;
    logic        trigHit;
    logic        armCmd;
    logic        clrStats;
    logic [31:0] rdv;
    wr = 1'b0;
    rd = 1'b0;
    extEdge = 1'b0;
    trigHit = 1'b0;
    armCmd = 1'b0;
    clrStats = 1'b0;
    rdv = 32'h0000_0000;
    next_r = r;
    next_r.rs1 = 1'b1;
    next_r.rs2 = r.rs1;
    memWe = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.sampleStart = 1'b0;
    next_r.streamValid = 1'b0;
    next_r.errPulse = 1'b0;
    next_r.busTrig = 1'b0;
    next_r.ext1 = extTrig;
    next_r.ext2 = r.ext1;
    next_r.ext3 = r.ext2;
    extEdge = r.ext2 & ~r.ext3;
    wr = psel & penable & ~r.pready & pwrite;
    rd = psel & penable & ~r.pready & ~pwrite;
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
    end
    if (wr) begin
      unique case (paddr)
        tsq_pkg::A_CTRL: begin
          next_r.trigSrc = pwdata[1:0];
          next_r.storeEn = pwdata[2];
          next_r.autoDelay = pwdata[3];
          next_r.mathSel = pwdata[6:4];
          next_r.mathOn = pwdata[7] && (pwdata[6:4] != tsq_pkg::MATH_NONE);
          if (pwdata[7] && pwdata[6:4] == tsq_pkg::MATH_MINMAX
              && !(r.mathOn && r.mathSel == tsq_pkg::MATH_MINMAX)) begin
            clrStats = 1'b1;
          end
        end
        tsq_pkg::A_CMD: begin
          if (pwdata[tsq_pkg::CMD_ARM_STORE] || pwdata[tsq_pkg::CMD_ONE_SHOT]) begin
            armCmd = 1'b1;
            next_r.streamMode = 1'b0;
          end
          if (pwdata[tsq_pkg::CMD_ARM_STREAM]) begin
            armCmd = 1'b1;
            next_r.streamMode = 1'b1;
          end
          if (pwdata[tsq_pkg::CMD_ONE_SHOT] || pwdata[tsq_pkg::CMD_PRESET]) begin
            next_r.storeEn = 1'b1;
          end
          if (pwdata[tsq_pkg::CMD_BUS_TRIG]) begin
            next_r.busTrig = 1'b1;
          end
          if (pwdata[tsq_pkg::CMD_IF_RESET]) begin
            clrStats = 1'b1;
            next_r.mathOn = 1'b0;
          end
        end
        tsq_pkg::A_DELAY: begin
          if (pwdata <= tsq_pkg::MAX_DELAY_MS) begin
            next_r.delayMs = pwdata;
            next_r.autoDelay = 1'b0;
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
        tsq_pkg::A_SAMPLES: begin
          if (pwdata != 32'h0000_0000 && pwdata <= tsq_pkg::MAX_COUNT) begin
            next_r.samples = pwdata;
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
        tsq_pkg::A_TRIGS: begin
          if (pwdata <= tsq_pkg::MAX_COUNT) begin
            next_r.trigs = pwdata;
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
        tsq_pkg::A_NULL: begin
          if (r.mathOn && r.mathSel == tsq_pkg::MATH_NULL
              && inRange(pwdata, tsq_pkg::LIM120)) begin
            next_r.nullVal = pwdata;
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
        tsq_pkg::A_DBREL: begin
          if (r.mathOn && r.mathSel == tsq_pkg::MATH_DB && inRange(pwdata, tsq_pkg::DB_LIM)) begin
            next_r.dbRel = pwdata;
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
        tsq_pkg::A_DBMRES: begin
          if (dbmListed(pwdata)) begin
            next_r.dbmRes = pwdata[15:0];
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
        tsq_pkg::A_LOWER: begin
          if (inRange(pwdata, tsq_pkg::LIM120)) begin
            next_r.lower = pwdata;
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
        tsq_pkg::A_UPPER: begin
          if (inRange(pwdata, tsq_pkg::LIM120)) begin
            next_r.upper = pwdata;
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
        default: next_r.pslverr = 1'b1;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        tsq_pkg::A_CTRL: rdv = {24'h00_0000, r.mathOn, r.mathSel, r.autoDelay, r.storeEn,
                                r.trigSrc};
        tsq_pkg::A_STATUS: rdv = {28'h000_0000, r.streamMode, r.busy, r.st};
        tsq_pkg::A_DELAY: rdv = r.delayMs;
        tsq_pkg::A_SAMPLES: rdv = r.samples;
        tsq_pkg::A_TRIGS: rdv = (r.trigs == tsq_pkg::INF_COUNT) ? tsq_pkg::INF_READBACK : r.trigs;
        tsq_pkg::A_NULL: rdv = r.nullVal;
        tsq_pkg::A_DBREL: rdv = r.dbRel;
        tsq_pkg::A_DBMRES: rdv = {16'h0000, r.dbmRes};
        tsq_pkg::A_LOWER: rdv = r.lower;
        tsq_pkg::A_UPPER: rdv = r.upper;
        tsq_pkg::A_MIN: rdv = r.minV;
        tsq_pkg::A_MAX: rdv = r.maxV;
        tsq_pkg::A_AVG: rdv = (r.cnt == 32'h0000_0000) ? 32'h0000_0000
                              : 32'($signed(r.sum) / $signed({16'h0000, r.cnt}));
        tsq_pkg::A_CNT: rdv = r.cnt;
        tsq_pkg::A_POINTS: rdv = {22'h00_0000, r.points};
        tsq_pkg::A_FETCH: begin
          if (!r.storeEn) begin
            next_r.pslverr = 1'b1;
            next_r.errPulse = 1'b1;
          end else if (r.rdPtr < r.points) begin
            rdv = mem[r.rdPtr[tsq_pkg::MEM_AW-1:0]];
            next_r.rdPtr = r.rdPtr + 10'd1;
          end
        end
        default: next_r.pslverr = 1'b1;
      endcase
      next_r.prdata = rdv;
    end
    if (localMode && r.st == tsq_pkg::TSQ_IDLE) begin
      next_r.st = tsq_pkg::TSQ_WAIT;
      next_r.trigDone = 32'h0000_0000;
    end
    if (armCmd && r.st == tsq_pkg::TSQ_IDLE) begin
      next_r.st = tsq_pkg::TSQ_SETUP;
      next_r.setupCnt = 32'(tsq_pkg::SETUP_CYC);
      next_r.trigDone = 32'h0000_0000;
      next_r.points = 10'd0;
      next_r.rdPtr = 10'd0;
    end
    if (r.st == tsq_pkg::TSQ_SETUP) begin
      if (r.setupCnt <= 32'h0000_0001) begin
        next_r.st = tsq_pkg::TSQ_WAIT;
      end else begin
        next_r.setupCnt = r.setupCnt - 32'h0000_0001;
      end
    end
    unique case (r.trigSrc)
      tsq_pkg::SRC_BUS: trigHit = r.busTrig;
      tsq_pkg::SRC_EXT: trigHit = extEdge;
      default: trigHit = 1'b1;
    endcase
    if (r.st == tsq_pkg::TSQ_WAIT && trigHit) begin
      next_r.st = tsq_pkg::TSQ_MEAS;
      next_r.sampLeft = r.samples;
      next_r.delaying = 1'b1;
      next_r.delayLeft = r.autoDelay ? {24'h00_0000, autoDelayMs} : r.delayMs;
      next_r.usCnt = 32'h0000_0000;
      next_r.msCnt = 32'h0000_0000;
    end
    if (r.st == tsq_pkg::TSQ_MEAS) begin
      if (r.delaying) begin
        if (r.msCnt >= r.delayLeft) begin
          next_r.delaying = 1'b0;
          next_r.busy = 1'b1;
          next_r.sampleStart = 1'b1;
        end else if (r.usCnt == 32'(1000 * tsq_pkg::US_CYC - 1)) begin
          next_r.usCnt = 32'h0000_0000;
          next_r.msCnt = r.msCnt + 32'h0000_0001;
        end else begin
          next_r.usCnt = r.usCnt + 32'h0000_0001;
        end
      end else if (r.busy && sampleDone) begin
        next_r.busy = 1'b0;
        if (r.streamMode) begin
          next_r.streamValid = 1'b1;
          next_r.streamData = sampleValue;
        end else if (r.storeEn && r.points < 10'(tsq_pkg::MEM_DEPTH)) begin
          memWe = 1'b1;
          next_r.points = r.points + 10'd1;
        end
        if (r.mathOn && r.mathSel == tsq_pkg::MATH_MINMAX) begin
          if (r.cnt == 32'h0000_0000 || $signed(sampleValue) < $signed(r.minV)) begin
            next_r.minV = sampleValue;
          end
          if (r.cnt == 32'h0000_0000 || $signed(sampleValue) > $signed(r.maxV)) begin
            next_r.maxV = sampleValue;
          end
          next_r.cnt = r.cnt + 32'h0000_0001;
          next_r.sum = r.sum + {{16{sampleValue[31]}}, sampleValue};
        end
        if (r.sampLeft > 32'h0000_0001) begin
          next_r.sampLeft = r.sampLeft - 32'h0000_0001;
          next_r.delaying = 1'b1;
          next_r.msCnt = 32'h0000_0000;
          next_r.usCnt = 32'h0000_0000;
        end else begin
          next_r.trigDone = r.trigDone + 32'h0000_0001;
          if (!localMode && r.trigs != tsq_pkg::INF_COUNT
              && r.trigDone + 32'h0000_0001 >= r.trigs) begin
            next_r.st = tsq_pkg::TSQ_IDLE;
          end else begin
            next_r.st = tsq_pkg::TSQ_WAIT;
          end
        end
      end
    end
    if (wr && paddr == tsq_pkg::A_CMD && pwdata[tsq_pkg::CMD_DEV_CLEAR]) begin
      next_r.st = tsq_pkg::TSQ_IDLE;
      next_r.busy = 1'b0;
      next_r.delaying = 1'b0;
    end
    if (clrStats) begin
      next_r.minV = 32'h0000_0000;
      next_r.maxV = 32'h0000_0000;
      next_r.sum = 48'h0000_0000_0000;
      next_r.cnt = 32'h0000_0000;
    end
    next_r.waitTrig = (next_r.st == tsq_pkg::TSQ_WAIT);
  end

  always_ff @(posedge core_clk) begin
    if (memWe) begin
      mem[r.points[tsq_pkg::MEM_AW-1:0]] <= sampleValue;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.trigSrc <= tsq_pkg::SRC_IMM;
      r.storeEn <= 1'b1;
      r.autoDelay <= 1'b1;
      r.samples <= 32'h0000_0001;
      r.trigs <= 32'h0000_0001;
      r.dbmRes <= tsq_pkg::DBM_DEFAULT;
    end else if (!rstSync) begin
      r <= '0;
      r.rs1 <= 1'b1;
      r.rs2 <= r.rs1;
      r.trigSrc <= tsq_pkg::SRC_IMM;
      r.storeEn <= 1'b1;
      r.autoDelay <= 1'b1;
      r.samples <= 32'h0000_0001;
      r.trigs <= 32'h0000_0001;
      r.dbmRes <= tsq_pkg::DBM_DEFAULT;
    end else begin
      r <= next_r;
    end
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign sampleStart = r.sampleStart;
  assign streamValid = r.streamValid;
  assign streamData = r.streamData;
  assign waitTrig = r.waitTrig;
  assign errPulse = r.errPulse;
endmodule : tsq_trigger_sequencer

// >>> dv/tsq_chk.sv
// Port checker for the trigger sequencer
`timescale 1ns/1ps
module tsq_chk (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sampleStart,
  input wire logic        errPulse
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  pready_late_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  pready_one_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_req_a: assert property (pready |-> psel && penable)
    else $error("pready without access");
  slverr_with_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_hold_a: assert property (!(psel && penable && !pwrite && !pready) |=> $stable(prdata))
    else $error("prdata changed outside a read");
  start_pulse_a: assert property (sampleStart |=> !sampleStart)
    else $error("sampleStart longer than one cycle");
  err_pulse_a: assert property (errPulse |=> !errPulse)
    else $error("errPulse longer than one cycle");
  err_cause_a: assert property ($rose(errPulse) |-> pready && pslverr)
    else $error("errPulse without refused access");

  cover property (sampleStart);
  cover property (errPulse);
  cover property (pready && pslverr);
endmodule : tsq_chk

bind tsq_trigger_sequencer tsq_chk u_chk (
  .core_clk   (core_clk),
  .reset_n    (reset_n),
  .psel       (psel),
  .penable    (penable),
  .pwrite     (pwrite),
  .pready     (pready),
  .prdata     (prdata),
  .pslverr    (pslverr),
  .sampleStart(sampleStart),
  .errPulse   (errPulse)
);

// >>> dv/tsq_conv_model.sv
// Converter model answering each sample request with a reading
`timescale 1ns/1ps
module tsq_conv_model (
  input  wire logic        core_clk,
  input  wire logic        sampleStart,
  output logic             sampleDone,
  output logic [31:0]      sampleValue
);
  logic [31:0] vals [3] = '{32'h0000_0004, 32'hFFFF_FFFE, 32'h0000_0007};
  int          idx = 0;
  int          cnt = 0;
  initial begin
    sampleDone = 1'h0;
    sampleValue = 32'h0000_0000;
  end
  // Value is junk outside the done cycle
  always @(posedge core_clk) begin
    sampleDone <= 1'h0;
    sampleValue <= ~sampleValue;
    if (sampleStart === 1'h1) begin
      cnt <= 3;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        sampleDone <= 1'h1;
        sampleValue <= vals[idx];
        idx <= (idx + 1) % 3;
      end
    end
  end
endmodule : tsq_conv_model

// >>> dv/testbench.sv
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ps
module testbench;
  logic        core_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        extTrig;
  logic        localMode;
  logic        sampleDone;
  logic [31:0] sampleValue;
  logic [7:0]  autoDelayMs;
  logic        sampleStart;
  logic        streamValid;
  logic [31:0] streamData;
  logic        waitTrig;
  logic        errPulse;
  logic        errSeen;
  int          errors;
  int          n_checks;
  int          nStart;
  int          nDone;
  int          nStream;
  logic [31:0] lastStream;
  localparam logic [31:0] LT [5][4] = '{
    '{32'h0000_009D, 32'h0000_0018, 32'h0001_D4C0, 32'h0001_D4C1},
    '{32'h0000_00BD, 32'h0000_001C, 32'hFFFF_B1E0, 32'hFFFF_B1DF},
    '{32'h0000_00CD, 32'h0000_0020, 32'h0000_004B, 32'h0000_004C},
    '{32'h0000_00DD, 32'h0000_0024, 32'hFFFE_2B40, 32'hFFFE_2B3F},
    '{32'h0000_00DD, 32'h0000_0028, 32'h0001_D4C0, 32'h0001_D4C1}};

  tsq_trigger_sequencer DUT (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .extTrig(extTrig), .localMode(localMode),
    .sampleDone(sampleDone), .sampleValue(sampleValue), .autoDelayMs(autoDelayMs),
    .sampleStart(sampleStart), .streamValid(streamValid), .streamData(streamData),
    .waitTrig(waitTrig), .errPulse(errPulse));
  tsq_conv_model u_conv (.core_clk(core_clk), .sampleStart(sampleStart),
    .sampleDone(sampleDone), .sampleValue(sampleValue));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (sampleStart === 1'h1) nStart <= nStart + 1;
    if (sampleDone === 1'h1) nDone <= nDone + 1;
    if (errPulse === 1'h1) errSeen <= 1'h1;
    if (streamValid === 1'h1) begin
      nStream <= nStream + 1;
      lastStream <= streamData;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int t;
    t = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'h1 && t < 50);
    if (pready !== 1'h1) begin
      errors++;
      $display("unexpected at %0t: no pready", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
    chk(32'(e), 32'(ee));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0000_0000, r, e);
    chk(r & m, exp);
    chk(32'(e), 32'h0000_0000);
  endtask : rd

  task automatic t_defaults();
    logic [31:0] r;
    logic        e;
    rd(tsq_pkg::A_CTRL, 32'h0000_000D, 32'h0000_00FF);
    rd(tsq_pkg::A_SAMPLES, 32'h0000_0001, 32'hFFFF_FFFF);
    rd(tsq_pkg::A_TRIGS, 32'h0000_0001, 32'hFFFF_FFFF);
    rd(tsq_pkg::A_DBMRES, 32'h0000_0258, 32'hFFFF_FFFF);
    apb(1'h0, 8'hFC, 32'h0000_0000, r, e);
    chk(32'(e), 32'h0000_0001);
  endtask : t_defaults
  task automatic t_limits();
    wr(tsq_pkg::A_NULL, 32'h0000_0005, 1'h1);
    for (int i = 0; i < 5; i++) begin
      // Math enabled before register write
      wr(tsq_pkg::A_CTRL, LT[i][0], 1'h0);
      wr(LT[i][1][7:0], LT[i][2], 1'h0);
      wr(LT[i][1][7:0], LT[i][3], 1'h1);
      rd(LT[i][1][7:0], LT[i][2], 32'hFFFF_FFFF);
    end
  endtask : t_limits
  task automatic t_counts();
    wr(tsq_pkg::A_TRIGS, 32'h0000_0000, 1'h0);
    rd(tsq_pkg::A_TRIGS, 32'h7E94_F56A, 32'hFFFF_FFFF);
    wr(tsq_pkg::A_TRIGS, 32'h0000_C351, 1'h1);
    wr(tsq_pkg::A_SAMPLES, 32'h0000_0000, 1'h1);
    wr(tsq_pkg::A_SAMPLES, 32'h0000_0003, 1'h0);
    wr(tsq_pkg::A_DELAY, 32'h0036_EE81, 1'h1);
    wr(tsq_pkg::A_DELAY, 32'h0000_0000, 1'h0);
    rd(tsq_pkg::A_CTRL, 32'h0000_0000, 32'h0000_0008);
  endtask : t_counts
  task automatic t_stats();
    int t;
    nStart = 0;
    nDone = 0;
    wr(tsq_pkg::A_CTRL, 32'h0000_00A4, 1'h0);
    localMode <= 1'h1;
    wr(tsq_pkg::A_CMD, 32'h0000_0010, 1'h0);
    wr(tsq_pkg::A_CMD, 32'h0000_0010, 1'h0);
    t = 0;
    while (nDone < 3 && t < 300) begin
      @(posedge core_clk);
      t++;
    end
    repeat (30) @(posedge core_clk);
    chk(nStart, 32'h0000_0003);
    chk(nDone, 32'h0000_0003);
    rd(tsq_pkg::A_MIN, 32'hFFFF_FFFE, 32'hFFFF_FFFF);
    rd(tsq_pkg::A_MAX, 32'h0000_0007, 32'hFFFF_FFFF);
    rd(tsq_pkg::A_AVG, 32'h0000_0003, 32'hFFFF_FFFF);
    rd(tsq_pkg::A_CNT, 32'h0000_0003, 32'hFFFF_FFFF);
    rd(tsq_pkg::A_POINTS, 32'h0000_0003, 32'hFFFF_FFFF);
    localMode <= 1'h0;
    wr(tsq_pkg::A_CMD, 32'h0000_0040, 1'h0);
    rd(tsq_pkg::A_MAX, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(tsq_pkg::A_CNT, 32'h0000_0000, 32'hFFFF_FFFF);
  endtask : t_stats
  task automatic t_store();
    logic [31:0] r;
    logic        e;
    errSeen = 1'h0;
    wr(tsq_pkg::A_CTRL, 32'h0000_0000, 1'h0);
    apb(1'h0, tsq_pkg::A_FETCH, 32'h0000_0000, r, e);
    chk(32'(e), 32'h0000_0001);
    // Let the pulse monitor update first
    @(posedge core_clk);
    chk(32'(errSeen), 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      wr(tsq_pkg::A_CTRL, 32'h0000_0000, 1'h0);
      wr(tsq_pkg::A_CMD, i ? 32'h0000_0008 : 32'h0000_0004, 1'h0);
      rd(tsq_pkg::A_CTRL, 32'h0000_0004, 32'h0000_0004);
      wr(tsq_pkg::A_CMD, 32'h0000_0020, 1'h0);
    end
  endtask : t_store
  task automatic t_arm();
    nStart = 0;
    wr(tsq_pkg::A_CTRL, 32'h0000_0006, 1'h0);
    wr(tsq_pkg::A_CMD, 32'h0000_0001, 1'h0);
    rd(tsq_pkg::A_STATUS, 32'h0000_0001, 32'h0000_0003);
    extTrig <= 1'h1;
    repeat (3) @(posedge core_clk);
    extTrig <= 1'h0;
    repeat (10) @(posedge core_clk);
    chk(nStart, 32'h0000_0000);
    chk(32'(waitTrig), 32'h0000_0000);
    wr(tsq_pkg::A_CMD, 32'h0000_0020, 1'h0);
    rd(tsq_pkg::A_STATUS, 32'h0000_0000, 32'h0000_0003);
    wr(tsq_pkg::A_CMD, 32'h0000_0002, 1'h0);
    rd(tsq_pkg::A_STATUS, 32'h0000_0009, 32'h0000_000B);
    wr(tsq_pkg::A_CMD, 32'h0000_0020, 1'h0);
  endtask : t_arm
  task automatic t_stream();
    int t;
    nStream = 0;
    wr(tsq_pkg::A_TRIGS, 32'h0000_0001, 1'h0);
    // Local entry reaches wait without set-up, then remote again
    localMode <= 1'h1;
    repeat (2) @(posedge core_clk);
    localMode <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk(32'(waitTrig), 32'h0000_0001);
    extTrig <= 1'h1;
    repeat (3) @(posedge core_clk);
    extTrig <= 1'h0;
    t = 0;
    while (nStream < 3 && t < 100) begin
      @(posedge core_clk);
      t++;
    end
    repeat (10) @(posedge core_clk);
    chk(nStream, 32'h0000_0003);
    chk(lastStream, 32'h0000_0007);
    rd(tsq_pkg::A_STATUS, 32'h0000_0000, 32'h0000_0003);
  endtask : t_stream

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    stop_test();
  end
  initial begin
    reset_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    extTrig = 1'h0;
    localMode = 1'h0;
    autoDelayMs = 8'h00;
    errSeen = 1'h0;
    errors = 0;
    n_checks = 0;
    nStart = 0;
    nDone = 0;
    nStream = 0;
    lastStream = 32'h0000_0000;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    t_defaults();
    t_limits();
    t_counts();
    t_stats();
    t_store();
    t_arm();
    t_stream();
    stop_test();
  end
endmodule : testbench
